// ---- pkg/adc_ctrl_consts.svh ----
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH
`define OFS_CTRL1 12'h000
`define OFS_CTRL2 12'h004
`define OFS_RES_HI 12'h008
`define OFS_RES_LO 12'h00C
`define OFS_CMP_HI 12'h010
`define OFS_CMP_LO 12'h014
`define OFS_CFG 12'h018
`define OFS_PIN_A 12'h01C
`define OFS_PIN_B 12'h020
`define OFS_MODE 12'h024
`define CH_OFF 5'h1F
`define CH_TEMP 5'h1A
`define CH_BGAP 5'h1B
`define CH_VREFH 5'h1D
`define CH_VREFL 5'h1E
`define RES_BITS 10
`define SAMPLE_SHORT 4'h3
`define SAMPLE_LONG 4'hF
`define SETTLE_CYCLES 2'h3
`endif

// ---- pkg/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_DONE = 4'b1000
  } conv_state_e;
  typedef enum logic [1:0] {
    SRC_BUS = 2'h0,
    SRC_BUS_DIV2 = 2'h1,
    SRC_ALT = 2'h2,
    SRC_LOCAL = 2'h3
  } clk_src_t;
  typedef enum logic [2:0] {
    IN_PIN = 3'h0,
    IN_VREFL = 3'h1,
    IN_VREFH = 3'h2,
    IN_TEMP = 3'h3,
    IN_BGAP = 3'h4,
    IN_UNDEF = 3'h5,
    IN_OFF = 3'h6
  } input_kind_t;
endpackage

// ---- core/conv_tick_gen.sv ----
`timescale 1ns/1ns
// makes a one-cycle conversion clock tick from the chosen source
module conv_tick_gen
  import adc_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] clk_src,
  input wire logic [1:0] clock_divide_field,
  input wire logic alternate_conv_clock,
  input wire logic local_async_conv_clock,
  input wire logic deep_stop_mode,
  output logic conv_tick
);
  logic [2:0] alt_sync;
  logic [2:0] loc_sync;
  logic [3:0] div_cnt;
  logic [3:0] div_lim;
  logic src_edge;
  logic bus_half;
  // both slow sources pass two flops; third stage only feeds the edge detect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alt_sync <= 3'h0;
      loc_sync <= 3'h0;
      bus_half <= 1'b0;
    end
    else
    begin
      alt_sync <= {alt_sync[1:0], alternate_conv_clock};
      loc_sync <= {loc_sync[1:0], local_async_conv_clock};
      bus_half <= ~bus_half;
    end
  end
  // source choice; alternate clock blocked in deep stop
  always_comb
  begin
    unique case (clk_src_t'(clk_src))
      SRC_BUS: src_edge = 1'b1;
      SRC_BUS_DIV2: src_edge = bus_half;
      SRC_ALT: src_edge = alt_sync[1] & ~alt_sync[2] & ~deep_stop_mode;
      SRC_LOCAL: src_edge = loc_sync[1] & ~loc_sync[2];
    endcase
  end
  // divide by 1,2,4,8 applies to every source, alternate included
  assign div_lim = 4'((4'h1 << clock_divide_field) - 4'h1);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt <= 4'h0;
    else if (src_edge)
      div_cnt <= (div_cnt >= div_lim) ? 4'h0 : 4'(div_cnt + 4'h1);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conv_tick <= 1'b0;
    else
      conv_tick <= src_edge && (div_cnt >= div_lim);
  end
endmodule

// ---- core/hw_trig_sync.sv ----
`timescale 1ns/1ns
// catches rising edges of the periodic counter output as start pulses
module hw_trig_sync
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hw_conv_trigger,
  output logic trig_pulse
);
  logic [2:0] sync;
  // not gated by deep stop: a counter on the slow source keeps firing
  // two flops then edge detect, so one edge gives exactly one pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync <= 3'h0;
      trig_pulse <= 1'b0;
    end
    else
    begin
      sync <= {sync[1:0], hw_conv_trigger};
      trig_pulse <= sync[1] & ~sync[2]; // rising edge only
    end
  end
endmodule

// ---- core/adc_ctrl.sv ----
`timescale 1ns/1ns
`include "adc_ctrl_consts.svh"
// converter control: apb registers, channel decode, sequencing, compare
module adc_ctrl
  import adc_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic alternate_conv_clock,
  input wire logic local_async_conv_clock,
  input wire logic hw_conv_trigger,
  input wire logic deep_stop_mode,
  input wire logic comp_in,
  output logic [4:0] channel_select_field,
  output logic [2:0] input_kind,
  output logic [15:0] analog_pin_enable,
  output logic sar_power_on,
  output logic sample_switch,
  output logic [9:0] dac_code,
  output logic conv_irq
);
  logic [1:0] comp_sync;
  logic [1:0] settle;
  logic [4:0] chan;
  logic irq_en;
  logic cont;
  logic hw_trig_en;
  logic cmp_en;
  logic cmp_ge;
  logic [9:0] cmp_val;
  logic long_sample;
  logic low_power;
  logic eight_bit;
  logic [1:0] clk_src;
  logic [1:0] clk_div;
  logic [7:0] pin_a;
  logic [7:0] pin_b;
  logic conv_complete_flag;
  logic [9:0] result;
  logic [9:0] sar;
  logic [9:0] bit_mask;
  logic [3:0] samp_cnt;
  conv_state_e state;
  conv_state_e next_state;
  logic conv_tick;
  logic trig_pulse;
  logic comp_bit;
  // eight-bit mode drops the two lsbs, still right-justified
  function automatic logic [9:0] fmt_res(input logic [9:0] v, input logic eight);
    fmt_res = eight ? {2'h0, v[9:2]} : v;
  endfunction
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire wr_ctrl1 = wr && (paddr == `OFS_CTRL1);
  wire rd_res_lo = rd && (paddr == `OFS_RES_LO);
  wire chan_off = (chan == `CH_OFF);
  wire sw_start = wr_ctrl1 && (pwdata[4:0] != `CH_OFF);
  wire hw_start = hw_trig_en && trig_pulse && !chan_off && (state == ST_IDLE);
  wire sar_step = (state == ST_CONVERT) && conv_tick && (settle == 2'h0);
  // trial bit resolved, so compare and result see the final code
  wire [9:0] sar_kept = comp_bit ? sar : (sar & ~bit_mask);
  wire [9:0] fmt_result = fmt_res(sar_kept, eight_bit);
  wire cmp_true = cmp_ge ? (fmt_result >= cmp_val) : (fmt_result < cmp_val);
  wire conv_done = sar_step && bit_mask[0];
  // a restart while already sampling must reload as well
  wire load_samp = (next_state == ST_SAMPLE) && (state != ST_SAMPLE || wr_ctrl1);
  wire set_flag = conv_done && (!cmp_en || cmp_true);
  wire [3:0] samp_len = long_sample ? `SAMPLE_LONG : `SAMPLE_SHORT;
  wire addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `OFS_MODE);

  // comparator sits on the analog side, so it gets two flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      comp_sync <= 2'h0;
    else
      comp_sync <= {comp_sync[0], comp_in};
  end
  assign comp_bit = comp_sync[1];

  // comparator answer trails a new trial code by three flops, so steps wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      settle <= 2'h0;
    else if (load_samp || sar_step)
      settle <= `SETTLE_CYCLES;
    else if (settle != 2'h0)
      settle <= 2'(settle - 2'h1);
  end

  conv_tick_gen u_tick
  (
    .pclk(pclk),
    .presetn(presetn),
    .clk_src(clk_src),
    .clock_divide_field(clk_div),
    .alternate_conv_clock(alternate_conv_clock),
    .local_async_conv_clock(local_async_conv_clock),
    .deep_stop_mode(deep_stop_mode),
    .conv_tick(conv_tick)
  );

  hw_trig_sync u_trig
  (
    .pclk(pclk),
    .presetn(presetn),
    .hw_conv_trigger(hw_conv_trigger),
    .trig_pulse(trig_pulse)
  );

  // control registers; cleared on reset with converter off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan <= `CH_OFF;
      irq_en <= 1'b0;
      cont <= 1'b0;
      hw_trig_en <= 1'b0;
      cmp_en <= 1'b0;
      cmp_ge <= 1'b0;
      cmp_val <= 10'h000;
      long_sample <= 1'b0;
      low_power <= 1'b0;
      eight_bit <= 1'b0;
      clk_src <= 2'h0;
      clk_div <= 2'h0;
      pin_a <= 8'h00;
      pin_b <= 8'h00;
    end
    else if (wr)
    begin
      if (paddr == `OFS_CTRL1)
      begin
        chan <= pwdata[4:0];
        cont <= pwdata[5];
        irq_en <= pwdata[6];
      end
      if (paddr == `OFS_CTRL2)
      begin
        cmp_ge <= pwdata[4];
        cmp_en <= pwdata[5];
        hw_trig_en <= pwdata[6];
      end
      if (paddr == `OFS_CMP_HI)
        cmp_val[9:8] <= pwdata[1:0];
      if (paddr == `OFS_CMP_LO)
        cmp_val[7:0] <= pwdata[7:0];
      if (paddr == `OFS_CFG)
      begin
        clk_src <= pwdata[1:0];
        eight_bit <= !pwdata[2];
        long_sample <= pwdata[4];
        clk_div <= pwdata[6:5];
        low_power <= pwdata[7];
      end
      if (paddr == `OFS_PIN_A)
        pin_a <= pwdata[7:0];
      if (paddr == `OFS_PIN_B)
        pin_b <= pwdata[7:0];
    end
  end

  // sequencer: sample, then one bit per conversion tick that comes once settle is zero
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (hw_start) next_state = ST_SAMPLE;
      ST_SAMPLE: if (conv_tick && samp_cnt == 4'h0) next_state = ST_CONVERT;
      ST_CONVERT: if (conv_done) next_state = ST_DONE;
      // continuous repeats unless hardware trigger is enabled; single returns to idle
      ST_DONE: next_state = (cont && !hw_trig_en) ? ST_SAMPLE : ST_IDLE;
    endcase
    if (sw_start && !hw_trig_en)
      next_state = ST_SAMPLE; // write aborts and restarts
    else if (wr_ctrl1)
      next_state = ST_IDLE;
    else if (chan_off)
      next_state = ST_IDLE; // no extra conversion when switched off
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // successive approximation, msb first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sar <= 10'h000;
      bit_mask <= 10'h000;
      samp_cnt <= 4'h0;
    end
    else if (load_samp)
    begin
      samp_cnt <= samp_len;
      sar <= 10'h200;
      bit_mask <= 10'h200;
    end
    else if (state == ST_SAMPLE && conv_tick && samp_cnt != 4'h0)
      samp_cnt <= 4'(samp_cnt - 4'h1);
    else if (sar_step)
    begin
      // keep trial bit if input above dac level, then try next bit
      sar <= sar_kept | (bit_mask >> 1);
      bit_mask <= bit_mask >> 1;
    end
  end

  // result kept until the next finished conversion that passes the compare, or any one when compare is off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result <= 10'h000;
    else if (conv_done && (!cmp_en || cmp_true))
      result <= sar_kept;
  end

  // flag: set wins over the clear by write or low read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conv_complete_flag <= 1'b0;
    else if (set_flag)
      conv_complete_flag <= 1'b1;
    else if (wr_ctrl1 || rd_res_lo)
      conv_complete_flag <= 1'b0;
  end

  // read mux; reserved bits read zero
  logic [31:0] rdata_mux;
  wire [9:0] res_out = fmt_res(result, eight_bit);
  always_comb
  begin
    rdata_mux = 32'h0;
    unique case (paddr)
      `OFS_CTRL1: rdata_mux = {24'h0, conv_complete_flag, irq_en, cont, chan};
      `OFS_CTRL2: rdata_mux = {24'h0, (state != ST_IDLE), hw_trig_en, cmp_en, cmp_ge, 4'h0};
      `OFS_RES_HI: rdata_mux = {30'h0, res_out[9:8]};
      `OFS_RES_LO: rdata_mux = {24'h0, res_out[7:0]};
      `OFS_CMP_HI: rdata_mux = {30'h0, cmp_val[9:8]};
      `OFS_CMP_LO: rdata_mux = {24'h0, cmp_val[7:0]};
      `OFS_CFG: rdata_mux = {24'h0, low_power, clk_div, long_sample, 1'b0, !eight_bit, clk_src};
      `OFS_PIN_A: rdata_mux = {24'h0, pin_a};
      `OFS_PIN_B: rdata_mux = {24'h0, pin_b};
      default: rdata_mux = 32'h0;
    endcase
  end

  // apb answer: zero wait state, error on unmapped address
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= (psel && !penable && !pwrite) ? rdata_mux : prdata;
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // channel decode onto analog mux controls
  logic [2:0] kind;
  always_comb
  begin
    if (chan[4] == 1'b0)
      kind = IN_PIN;
    else if (chan <= 5'h15)
      kind = IN_VREFL;
    else if (chan == `CH_TEMP)
      kind = IN_TEMP;
    else if (chan == `CH_BGAP)
      kind = IN_BGAP; // bandgap buffer enable is software's job
    else if (chan == `CH_VREFH)
      kind = IN_VREFH;
    else if (chan == `CH_VREFL)
      kind = IN_VREFL;
    else if (chan_off)
      kind = IN_OFF;
    else
      kind = IN_UNDEF; // result meaningless here
  end

  // all outputs registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      channel_select_field <= `CH_OFF;
      input_kind <= IN_OFF;
      analog_pin_enable <= 16'h0000;
      sar_power_on <= 1'b0;
      sample_switch <= 1'b0;
      dac_code <= 10'h000;
      conv_irq <= 1'b0;
    end
    else
    begin
      channel_select_field <= chan;
      input_kind <= kind;
      analog_pin_enable <= {pin_b, pin_a};
      sar_power_on <= !chan_off && (state != ST_IDLE || cont);
      sample_switch <= (state == ST_SAMPLE);
      dac_code <= sar;
      conv_irq <= conv_complete_flag && irq_en;
    end
  end
endmodule

// ---- bench/adc_ctrl_properties.sv ----
`timescale 1ns/1ns
// watches channel decode, converter power and bus answers
module adc_ctrl_properties
  import adc_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [4:0] channel_select_field,
  input wire logic [2:0] input_kind,
  input wire logic sar_power_on,
  input wire logic sample_switch
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // short alias keeps the decode checks readable
  wire [4:0] ch;
  assign ch = channel_select_field;

  AST_PIN_KIND: assert property (ch < 5'h10 |-> input_kind == IN_PIN)
    else $error("pin code not routed to pin");
  AST_VREFL_KIND: assert property (ch inside {[5'h10:5'h15]} |-> input_kind == IN_VREFL)
    else $error("unimplemented code not on low reference");
  AST_UNDEF_KIND: assert property (ch inside {[5'h16:5'h19], 5'h1C} |-> input_kind == IN_UNDEF)
    else $error("reserved code not marked undefined");
  AST_TEMP_KIND: assert property (ch == 5'h1A |-> input_kind == IN_TEMP)
    else $error("temperature code misrouted");
  AST_OFF_KIND: assert property (ch == 5'h1F |-> input_kind == IN_OFF && !sar_power_on)
    else $error("all-ones channel left converter powered");
  AST_SAMPLE_POWER: assert property (sample_switch |-> sar_power_on)
    else $error("sampling while powered off");
  AST_CHAN_WRITE: assert property (psel && penable && pwrite && paddr == 12'h000
    |-> ##2 ch == $past(pwdata[4:0], 2))
    else $error("channel not taken from control write");
  AST_READY_PULSE: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer not a single cycle after setup");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready && psel && penable)
    else $error("error flag outside access cycle");
endmodule

bind adc_ctrl adc_ctrl_properties u_adc_ctrl_properties (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .channel_select_field(channel_select_field),
  .input_kind(input_kind), .sar_power_on(sar_power_on), .sample_switch(sample_switch));

// ---- bench/analog_side.sv ----
`timescale 1ns/1ns
// far-side analog: comparator of the selected level against the trial code
module analog_side
  import adc_ctrl_pkg::*;
(
  input wire logic [4:0] channel_select_field,
  input wire logic [2:0] input_kind,
  input wire logic [15:0] analog_pin_enable,
  input wire logic [9:0] dac_code,
  output logic comp_in
);
  logic [9:0] level;
  // a pin left digital reads low; undefined codes wander with each trial
  always_comb
  begin
    case (input_kind)
      IN_PIN: level = analog_pin_enable[channel_select_field[3:0]] ?
        {channel_select_field[3:0], 6'h15} : 10'h000;
      IN_VREFL: level = 10'h000;
      IN_VREFH: level = 10'h3FF;
      IN_TEMP: level = 10'h2C7;
      IN_BGAP: level = 10'h171;
      default: level = ~dac_code;
    endcase
  end
  // level sits mid-code, so equality counts as above
  assign comp_in = (level >= dac_code);
endmodule

// ---- bench/adc_ctrl_tb_top.sv ----
`timescale 1ns/1ns
// register-level bench: conversions run against the analog model
module adc_ctrl_tb_top;
  logic pclk, presetn, psel, penable, pwrite, alt_clk, loc_clk, trig, stop, comp_in;
  logic pready, pslverr, er, sar_power_on, conv_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] chan;
  logic [2:0] kind;
  logic [15:0] pin_en;
  logic [9:0] dac;
  int bad_count = 0;
  int num_checks = 0;
  int i;

  adc_ctrl u_adc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .alternate_conv_clock(alt_clk), .local_async_conv_clock(loc_clk),
    .hw_conv_trigger(trig), .deep_stop_mode(stop), .comp_in(comp_in),
    .channel_select_field(chan), .input_kind(kind), .analog_pin_enable(pin_en),
    .sar_power_on(sar_power_on), .sample_switch(), .dac_code(dac), .conv_irq(conv_irq));

  analog_side u_analog_side (.channel_select_field(chan), .input_kind(kind),
    .analog_pin_enable(pin_en), .dac_code(dac), .comp_in(comp_in));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // converter clocks unrelated to the bus clock
  always #11 alt_clk = ~alt_clk;
  always #17 loc_clk = ~loc_clk;

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s exp %h got %h", w, exp, got);
    end
  endtask

  // one setup cycle, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 50)
    begin
      bad_count++;
      $display("mismatch pready timeout");
      results();
    end
    else
    begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // bounded poll of the completion flag
  task automatic poll(input logic e, input string w);
    logic f;
    int k;
    f = 1'b0;
    for (k = 0; k < 60 && f !== 1'b1; k++)
    begin
      apb(1'b0, 12'h000, 32'h0);
      f = rd[7];
    end
    chk(w, 32'(f), 32'(e));
  endtask

  task automatic res(input logic [9:0] e, input string w);
    logic [31:0] hi;
    apb(1'b0, 12'h008, 32'h0);
    hi = rd;
    apb(1'b0, 12'h00C, 32'h0);
    chk(w, {22'h0, hi[1:0], rd[7:0]}, {22'h0, e});
  endtask

  task automatic conv(input logic [7:0] c, input logic [9:0] e, input string w);
    apb(1'b1, 12'h000, {24'h0, c});
    poll(1'b1, w);
    res(e, w);
  endtask

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    alt_clk = 1'b0;
    loc_clk = 1'b0;
    trig = 1'b0;
    stop = 1'b0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl1 reset", rd, 32'h1F);
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped", {er, rd[30:0]}, 32'h80000000);
    apb(1'b1, 12'h01C, 32'h08);
    apb(1'b1, 12'h020, 32'h40);
    apb(1'b1, 12'h018, 32'h04);
    conv(8'h03, 10'h0D5, "pin3");
    apb(1'b0, 12'h000, 32'h0);
    chk("flag after low read", rd, 32'h03);
    apb(1'b0, 12'h004, 32'h0);
    chk("idle after single", 32'(rd[7]), 32'h0);
    conv(8'h0E, 10'h395, "pin14");
    conv(8'h02, 10'h000, "pin2 digital");
    conv(8'h10, 10'h000, "code10");
    conv(8'h15, 10'h000, "code15");
    conv(8'h1A, 10'h2C7, "temp");
    conv(8'h1B, 10'h171, "bandgap");
    apb(1'b1, 12'h000, 32'h17);
    poll(1'b1, "reserved 17 completes");
    apb(1'b1, 12'h000, 32'h1C);
    poll(1'b1, "reserved 1C completes");
    conv(8'h1D, 10'h3FF, "vrefh");
    // every source, long sample; alternate divided, local in low power
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, 12'h018, {24'h0, i == 3, 1'b0, i == 2, 3'b101, i[1:0]});
      conv(8'h03, 10'h0D5, "source");
    end
    apb(1'b1, 12'h018, 32'h0);
    conv(8'h03, 10'h035, "eight bit");
    apb(1'b1, 12'h018, 32'h06);
    stop <= 1'b1;
    apb(1'b1, 12'h000, 32'h03);
    poll(1'b0, "alt in deep stop");
    stop <= 1'b0;
    conv(8'h03, 10'h0D5, "alt after stop");
    apb(1'b1, 12'h018, 32'h04);
    apb(1'b1, 12'h000, 32'h23);
    poll(1'b1, "cont first");
    res(10'h0D5, "cont res");
    poll(1'b1, "cont second");
    apb(1'b1, 12'h000, 32'h1F);
    apb(1'b0, 12'h004, 32'h0);
    chk("off busy", {rd[7], sar_power_on}, 32'h0);
    poll(1'b0, "no extra conv");
    apb(1'b1, 12'h000, 32'h43);
    poll(1'b1, "irq conv");
    chk("irq set", 32'(conv_irq), 32'h1);
    apb(1'b1, 12'h000, 32'h1F);
    apb(1'b0, 12'h000, 32'h0);
    chk("write clears", {rd[7], conv_irq}, 32'h0);
    apb(1'b1, 12'h014, 32'hD6);
    apb(1'b1, 12'h004, 32'h20);
    conv(8'h03, 10'h0D5, "cmp less");
    apb(1'b1, 12'h004, 32'h30);
    apb(1'b1, 12'h000, 32'h03);
    poll(1'b0, "cmp ge false");
    apb(1'b1, 12'h014, 32'hD5);
    conv(8'h03, 10'h0D5, "cmp ge true");
    apb(1'b1, 12'h004, 32'h40);
    apb(1'b1, 12'h000, 32'h03);
    poll(1'b0, "armed no edge");
    trig <= 1'b1;
    poll(1'b1, "trig rise");
    res(10'h0D5, "trig res");
    trig <= 1'b0;
    poll(1'b0, "trig fall");
    stop <= 1'b1;
    trig <= 1'b1;
    poll(1'b1, "trig second rise");
    results();
  end
endmodule
